// ---- hw/sacc_regs.svh ----
`ifndef SACC_REGS_SVH
`define SACC_REGS_SVH
// -----------------------------------------------------------------------------
// register offsets (8-bit register index of the serial control port)
// -----------------------------------------------------------------------------
`define SACC_OFS_PWR_MGMT_ONE 8'h01
`define SACC_OFS_CLOCKING_ONE 8'h06
`define SACC_OFS_SPK_MIX_ATTN 8'h22
`define SACC_OFS_SPK_DRV_CTRL 8'h25
`define SACC_OFS_CLOCKING_FOUR 8'h42
`define SACC_OFS_PWR_LIM_CTRL 8'h63
// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define SACC_BIT_OSCILLATOR_ENABLE 3
`define SACC_BIT_TO_HALVE_BYP 15
`define SACC_BIT_TO_ENA 14
`define SACC_BIT_LINEAR_MODE 12
`define SACC_BIT_FB_ATTEN 7
`define SACC_BIT_LIN_REF 6
`define SACC_BOOST_HI 5
`define SACC_BOOST_LO 3
`define SACC_BIT_TO_DIV16 8
`define SACC_BIT_TO_X4 7
`define SACC_BIT_PL_ENA 15
`define SACC_BIT_PL_RMS 12
`define SACC_THR_HI 11
`define SACC_THR_LO 8
`define SACC_ATK_HI 6
`define SACC_ATK_LO 4
`define SACC_DCY_HI 2
`define SACC_DCY_LO 0
// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define SACC_RST_BIT 1'b0
`define SACC_RST_PL_ENA 1'b1
`define SACC_RST_CODE3 3'h0
`define SACC_RST_CODE4 4'h0
// -----------------------------------------------------------------------------
// timing: fastest timeout period, class D and servo division ratios, sequencer tick prescaler value
// -----------------------------------------------------------------------------
`define SACC_CLK_MHZ 100
`define SACC_TO_MIN_PERIOD_US 1000
`define SACC_TO_BASE_CYCLES (`SACC_TO_MIN_PERIOD_US * `SACC_CLK_MHZ)
`define SACC_DIV_CLASSD 8'h08
`define SACC_DIV_SERVO 8'h40
`define SACC_DIV_SEQ 8'hC0
`endif

// ---- hw/sacc_pkg.sv ----
package sacc_pkg;
  // speaker driver topology selected by the linear mode bit
  typedef enum logic {
    SACC_CLASS_D,
    SACC_CLASS_AB
  } sacc_drv_mode_t;
endpackage : sacc_pkg

// ---- hw/sacc_ctrl_regs.sv ----
`timescale 1ns/10ps
`include "sacc_regs.svh"
module sacc_ctrl_regs #(
  parameter int unsigned TO_BASE_CYCLES = `SACC_TO_BASE_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [2:0] anticlip_attack_rate,
  input wire logic anticlip_trigger,
  input wire logic power_trigger,
  output logic oscillator_enable,
  output logic classd_clk_tick,
  output logic servo_clk_tick,
  output logic sequencer_clk_tick,
  output logic timeout_clock,
  output sacc_pkg::sacc_drv_mode_t speaker_drive_mode,
  output logic speaker_feedback_attenuate,
  output logic [3:0] speaker_attenuation_db,
  output logic speaker_linear_reference_sel,
  output logic [4:0] speaker_boost_half_db,
  output logic power_limit_enable,
  output logic power_measure_rms_sel,
  output logic [10:0] power_limit_threshold_mw,
  output logic [15:0] gain_reduce_rate_tenth_ms,
  output logic [12:0] gain_recover_rate_ms,
  output logic gain_recover_power_sel
);
  import sacc_pkg::*;

  // ---------------------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------------------
  // timeout period in cycles: base times 2 (no bypass), 4 (no x4), 16 (div16)
  function automatic logic [31:0] to_period(input logic byp, input logic x4,
                                            input logic d16);
    logic [2:0] sh;
    sh = {2'b00, ~byp} + {1'b0, ~x4, 1'b0} + {d16, 2'b00};
    return TO_BASE_CYCLES << sh;
  endfunction : to_period
  // power-limit attack rate in ms per 6 dB
  function automatic logic [12:0] pl_attack_ms(input logic [2:0] c);
    logic [12:0] t [8];
    t = '{13'h078, 13'h1E0, 13'h348, 13'h4B0, 13'h690, 13'h7F8, 13'hAC8, 13'hFF0};
    return t[c];
  endfunction : pl_attack_ms
  // power-limit decay rate in ms per 6 dB
  function automatic logic [12:0] pl_decay_ms(input logic [2:0] c);
    logic [12:0] t [8];
    t = '{13'h438, 13'h4B0, 13'h528, 13'h690, 13'h7F8, 13'hAC8, 13'hFF0, 13'h1FE0};
    return t[c];
  endfunction : pl_decay_ms
  // anti-clip attack rate in tenths of ms per 6 dB
  function automatic logic [15:0] clip_attack_tenth(input logic [2:0] c);
    logic [15:0] t [8];
    t = '{16'h0006, 16'h0036, 16'h0066, 16'h0096, 16'h00C6, 16'h00F6, 16'h0126, 16'h0155};
    return t[c];
  endfunction : clip_attack_tenth

  // ---------------------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------------------
  logic oscillator_enable_r; // system clock oscillator enable
  logic to_ena_r; // timeout clock gate
  logic to_byp_r; // 1 = skip the divide by two
  logic to_x4_r; // 1 = four times faster
  logic to_d16_r; // 1 = sixteen times slower
  logic lin_mode_r; // 1 = Class AB
  logic fb_att_r; // feedback attenuation request
  logic lin_ref_r; // Class AB reference select
  logic [2:0] boost_r; // speaker boost code
  logic pl_ena_r; // power limiter enable
  logic pl_rms_r; // power measurement mode
  logic [3:0] pl_thr_r; // power threshold code
  logic [2:0] pl_atk_r; // power attack code
  logic [2:0] pl_dcy_r; // power decay code
  // each register only takes its documented bits; the rest are dropped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oscillator_enable_r <= `SACC_RST_BIT;
      to_ena_r <= `SACC_RST_BIT;
      to_byp_r <= `SACC_RST_BIT;
      to_x4_r <= `SACC_RST_BIT;
      to_d16_r <= `SACC_RST_BIT;
      lin_mode_r <= `SACC_RST_BIT;
      fb_att_r <= `SACC_RST_BIT;
      lin_ref_r <= `SACC_RST_BIT;
      boost_r <= `SACC_RST_CODE3;
      pl_ena_r <= `SACC_RST_PL_ENA;
      pl_rms_r <= `SACC_RST_BIT;
      pl_thr_r <= `SACC_RST_CODE4;
      pl_atk_r <= `SACC_RST_CODE3;
      pl_dcy_r <= `SACC_RST_CODE3;
    end else if (reg_wr) begin
      case (reg_addr)
        `SACC_OFS_PWR_MGMT_ONE: oscillator_enable_r <= reg_wdata[`SACC_BIT_OSCILLATOR_ENABLE];
        `SACC_OFS_CLOCKING_ONE: begin
          to_byp_r <= reg_wdata[`SACC_BIT_TO_HALVE_BYP];
          to_ena_r <= reg_wdata[`SACC_BIT_TO_ENA];
        end
        `SACC_OFS_SPK_MIX_ATTN: lin_mode_r <= reg_wdata[`SACC_BIT_LINEAR_MODE];
        `SACC_OFS_SPK_DRV_CTRL: begin
          fb_att_r <= reg_wdata[`SACC_BIT_FB_ATTEN];
          lin_ref_r <= reg_wdata[`SACC_BIT_LIN_REF];
          boost_r <= reg_wdata[`SACC_BOOST_HI:`SACC_BOOST_LO];
        end
        `SACC_OFS_CLOCKING_FOUR: begin
          to_d16_r <= reg_wdata[`SACC_BIT_TO_DIV16];
          to_x4_r <= reg_wdata[`SACC_BIT_TO_X4];
        end
        `SACC_OFS_PWR_LIM_CTRL: begin
          pl_ena_r <= reg_wdata[`SACC_BIT_PL_ENA];
          pl_rms_r <= reg_wdata[`SACC_BIT_PL_RMS];
          pl_thr_r <= reg_wdata[`SACC_THR_HI:`SACC_THR_LO];
          pl_atk_r <= reg_wdata[`SACC_ATK_HI:`SACC_ATK_LO];
          pl_dcy_r <= reg_wdata[`SACC_DCY_HI:`SACC_DCY_LO];
        end
        default: begin
          // unmapped index: write ignored
        end
      endcase
    end
  end
  // ---------------------------------------------------------------------------
  // read port: data one cycle after the read strobe, unmapped reads zero
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= 16'h0000;
        case (reg_addr)
          `SACC_OFS_PWR_MGMT_ONE: reg_rdata[`SACC_BIT_OSCILLATOR_ENABLE] <= oscillator_enable_r;
          `SACC_OFS_CLOCKING_ONE: begin
            reg_rdata[`SACC_BIT_TO_HALVE_BYP] <= to_byp_r;
            reg_rdata[`SACC_BIT_TO_ENA] <= to_ena_r;
          end
          `SACC_OFS_SPK_MIX_ATTN: reg_rdata[`SACC_BIT_LINEAR_MODE] <= lin_mode_r;
          `SACC_OFS_SPK_DRV_CTRL: begin
            reg_rdata[`SACC_BIT_FB_ATTEN] <= fb_att_r;
            reg_rdata[`SACC_BIT_LIN_REF] <= lin_ref_r;
            reg_rdata[`SACC_BOOST_HI:`SACC_BOOST_LO] <= boost_r;
          end
          `SACC_OFS_CLOCKING_FOUR: begin
            reg_rdata[`SACC_BIT_TO_DIV16] <= to_d16_r;
            reg_rdata[`SACC_BIT_TO_X4] <= to_x4_r;
          end
          `SACC_OFS_PWR_LIM_CTRL: begin
            reg_rdata[`SACC_BIT_PL_ENA] <= pl_ena_r;
            reg_rdata[`SACC_BIT_PL_RMS] <= pl_rms_r;
            reg_rdata[`SACC_THR_HI:`SACC_THR_LO] <= pl_thr_r;
            reg_rdata[`SACC_ATK_HI:`SACC_ATK_LO] <= pl_atk_r;
            reg_rdata[`SACC_DCY_HI:`SACC_DCY_LO] <= pl_dcy_r;
          end
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end
  // ---------------------------------------------------------------------------
  // internal clock dividers, all running off the gated system clock
  // ---------------------------------------------------------------------------
  logic [7:0] sys_div_r; // free-running prescaler, cleared while oscillator off
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sys_div_r <= 8'h00;
    end else if (oscillator_enable_r) begin
      sys_div_r <= sys_div_r + 8'h01;
    end else begin
      sys_div_r <= 8'h00;
    end
  end
  // ticks mark the end of each sub-clock period; none while stopped
  assign classd_clk_tick = oscillator_enable_r
                           && ((sys_div_r & (`SACC_DIV_CLASSD - 8'h01)) == 8'h00);
  assign servo_clk_tick = oscillator_enable_r && ((sys_div_r & (`SACC_DIV_SERVO - 8'h01)) == 8'h00);
  assign sequencer_clk_tick = oscillator_enable_r && (sys_div_r == `SACC_DIV_SEQ);
  assign oscillator_enable = oscillator_enable_r;
  // ---------------------------------------------------------------------------
  // timeout clock: one-cycle enable pulse at the selected rate
  // ---------------------------------------------------------------------------
  logic [31:0] to_cnt_r; // cycles since the last timeout pulse
  logic [31:0] to_last; // terminal count for the current rate bits
  logic to_run; // counter may run
  assign to_last = to_period(to_byp_r, to_x4_r, to_d16_r) - 32'd1;
  assign to_run = oscillator_enable_r && to_ena_r;
  // a rate change mid-period takes effect at once; >= avoids a long wrap
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      to_cnt_r <= 32'd0;
      timeout_clock <= 1'b0;
    end else if (!to_run) begin
      to_cnt_r <= 32'd0;
      timeout_clock <= 1'b0;
    end else if (to_cnt_r >= to_last) begin
      to_cnt_r <= 32'd0;
      timeout_clock <= 1'b1;
    end else begin
      to_cnt_r <= to_cnt_r + 32'd1;
      timeout_clock <= 1'b0;
    end
  end
  // ---------------------------------------------------------------------------
  // speaker driver settings
  // ---------------------------------------------------------------------------
  assign speaker_drive_mode = lin_mode_r ? SACC_CLASS_AB : SACC_CLASS_D;
  assign speaker_feedback_attenuate = fb_att_r && lin_mode_r;
  assign speaker_attenuation_db = speaker_feedback_attenuate ? 4'hC : 4'h0;
  assign speaker_linear_reference_sel = lin_ref_r;
  // 1.5 dB steps are 3 half-dB steps; top code jumps to 12 dB in either mode
  // widen before the product so code 6 (18 half-dB) is not cut to three bits
  assign speaker_boost_half_db = (boost_r == 3'h7) ? 5'h18
                                 : 5'(boost_r) * 5'h03;
  // ---------------------------------------------------------------------------
  // power limiter settings and rate arbitration with anti-clip
  // ---------------------------------------------------------------------------
  logic [1:0] clip_sync_r; // pin-side trigger synchroniser
  logic [1:0] pwr_sync_r; // pin-side trigger synchroniser
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clip_sync_r <= 2'b00;
      pwr_sync_r <= 2'b00;
    end else begin
      clip_sync_r <= {clip_sync_r[0], anticlip_trigger};
      pwr_sync_r <= {pwr_sync_r[0], power_trigger};
    end
  end
  logic pwr_hit; // power threshold met while the limiter is on
  assign pwr_hit = pwr_sync_r[1] && pl_ena_r;
  assign power_limit_enable = pl_ena_r;
  assign power_measure_rms_sel = pl_rms_r;
  // products are widened first: 50 mW steps and x10 overflow the code width
  assign power_limit_threshold_mw = 11'h12C + 11'(pl_thr_r) * 11'h032;
  // joint trigger takes the faster clip attack but the power decay
  assign gain_reduce_rate_tenth_ms = clip_sync_r[1] ? clip_attack_tenth(anticlip_attack_rate)
                                     : 16'(pl_attack_ms(pl_atk_r)) * 16'h000A;
  assign gain_recover_power_sel = pwr_hit;
  assign gain_recover_rate_ms = pl_decay_ms(pl_dcy_r);
  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  sequence s_wr_bit(logic [7:0] a, int b, logic v);
    reg_wr && reg_addr == a && reg_wdata[b] == v;
  endsequence

  property p_osc_follow;
    @(posedge clock) disable iff (!rst_n)
      s_wr_bit(`SACC_OFS_PWR_MGMT_ONE, `SACC_BIT_OSCILLATOR_ENABLE, 1'b0) |=> !oscillator_enable
      ##1 !classd_clk_tick;
  endproperty
  a_osc_follow: assert property (p_osc_follow) else $error("oscillator not stopped");
  property p_to_gate;
    @(posedge clock) disable iff (!rst_n)
      !to_ena_r |=> !timeout_clock;
  endproperty
  a_to_gate: assert property (p_to_gate) else $error("timeout pulse while gated");
  property p_to_pulse;
    @(posedge clock) disable iff (!rst_n)
      timeout_clock |=> !timeout_clock;
  endproperty
  a_to_pulse: assert property (p_to_pulse) else $error("timeout pulse too long");
  property p_to_period;
    @(posedge clock) disable iff (!rst_n)
      (timeout_clock && to_run) |-> $past(to_cnt_r) >= $past(to_last);
  endproperty
  a_to_period: assert property (p_to_period) else $error("timeout pulse early");
  property p_classd_no_atten;
    @(posedge clock) disable iff (!rst_n)
      speaker_drive_mode == SACC_CLASS_D |-> speaker_attenuation_db == 4'h0;
  endproperty
  a_classd_no_atten: assert property (p_classd_no_atten) else $error("atten in class D");
  property p_boost;
    @(posedge clock) disable iff (!rst_n)
      s_wr_bit(`SACC_OFS_SPK_DRV_CTRL, `SACC_BOOST_HI, 1'b1) ##0 reg_wdata[4:3] == 2'b11
      |=> speaker_boost_half_db == 5'd24;
  endproperty
  a_boost: assert property (p_boost) else $error("top boost not 12 dB");
  property p_thr;
    @(posedge clock) disable iff (!rst_n)
      reg_wr && reg_addr == `SACC_OFS_PWR_LIM_CTRL && reg_wdata[11:8] == 4'hF
      |=> power_limit_threshold_mw == 11'd1050;
  endproperty
  a_thr: assert property (p_thr) else $error("threshold code 15 wrong");
  property p_joint;
    @(posedge clock) disable iff (!rst_n)
      (clip_sync_r[1] && pwr_hit) |-> gain_recover_power_sel
      && gain_reduce_rate_tenth_ms == clip_attack_tenth(anticlip_attack_rate);
  endproperty
  a_joint: assert property (p_joint) else $error("joint trigger rates wrong");
  property p_pl_ena;
    @(posedge clock) disable iff (!rst_n)
      s_wr_bit(`SACC_OFS_PWR_LIM_CTRL, `SACC_BIT_PL_ENA, 1'b0) |=> !power_limit_enable
      ##1 !gain_recover_power_sel;
  endproperty
  a_pl_ena: assert property (p_pl_ena) else $error("limiter not disabled");
  property p_mode;
    @(posedge clock) disable iff (!rst_n)
      s_wr_bit(`SACC_OFS_SPK_MIX_ATTN, `SACC_BIT_LINEAR_MODE, 1'b1)
      |=> speaker_drive_mode == SACC_CLASS_AB;
  endproperty
  a_mode: assert property (p_mode) else $error("class AB not selected");
  property p_rms;
    @(posedge clock) disable iff (!rst_n)
      s_wr_bit(`SACC_OFS_PWR_LIM_CTRL, `SACC_BIT_PL_RMS, 1'b1) |=> power_measure_rms_sel;
  endproperty
  a_rms: assert property (p_rms) else $error("rms mode not selected");

endmodule : sacc_ctrl_regs

// ---- testbench/sacc_ctrl_regs_tb.sv ----
`timescale 1ns/10ps
module sacc_ctrl_regs_tb;
  import sacc_pkg::*;
  // ---------------------------------------------------------------------------
  // bench signals
  // ---------------------------------------------------------------------------
  localparam int unsigned BASE = 4; // short timeout base keeps the run brief
  localparam logic [15:0] ATK_T [8] = '{16'h04B0, 16'h12C0, 16'h20D0, 16'h2EE0,
                                        16'h41A0, 16'h4FB0, 16'h6BD0, 16'h9F60};
  localparam logic [15:0] DCY_T [8] = '{16'h0438, 16'h04B0, 16'h0528, 16'h0690,
                                        16'h07F8, 16'h0AC8, 16'h0FF0, 16'h1FE0};
  logic clock = 1'b0;
  logic rst_n = 1'b0; // held low for five cycles
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [2:0] anticlip_attack_rate = 3'h3;
  logic anticlip_trigger = 1'b0;
  logic power_trigger = 1'b0;
  logic [15:0] reg_rdata;
  logic reg_rvalid, oscillator_enable, classd_clk_tick, servo_clk_tick;
  logic sequencer_clk_tick, timeout_clock, speaker_feedback_attenuate;
  logic speaker_linear_reference_sel, power_limit_enable, power_measure_rms_sel;
  logic gain_recover_power_sel;
  sacc_drv_mode_t speaker_drive_mode;
  logic [3:0] speaker_attenuation_db;
  logic [4:0] speaker_boost_half_db;
  logic [10:0] power_limit_threshold_mw;
  logic [15:0] gain_reduce_rate_tenth_ms;
  logic [12:0] gain_recover_rate_ms;
  int fail_count = 0;
  int samples_checked = 0;
  logic [15:0] rd;

  always #5 clock = ~clock;

  sacc_ctrl_regs #(.TO_BASE_CYCLES(BASE)) sacc_ctrl_regs_i (
    .clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .anticlip_attack_rate(anticlip_attack_rate),
    .anticlip_trigger(anticlip_trigger), .power_trigger(power_trigger),
    .oscillator_enable(oscillator_enable), .classd_clk_tick(classd_clk_tick),
    .servo_clk_tick(servo_clk_tick), .sequencer_clk_tick(sequencer_clk_tick),
    .timeout_clock(timeout_clock), .speaker_drive_mode(speaker_drive_mode),
    .speaker_feedback_attenuate(speaker_feedback_attenuate),
    .speaker_attenuation_db(speaker_attenuation_db),
    .speaker_linear_reference_sel(speaker_linear_reference_sel),
    .speaker_boost_half_db(speaker_boost_half_db),
    .power_limit_enable(power_limit_enable), .power_measure_rms_sel(power_measure_rms_sel),
    .power_limit_threshold_mw(power_limit_threshold_mw),
    .gain_reduce_rate_tenth_ms(gain_reduce_rate_tenth_ms),
    .gain_recover_rate_ms(gain_recover_rate_ms),
    .gain_recover_power_sel(gain_recover_power_sel)
  );

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  // four-state compare so an unknown never counts as a match
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one-cycle write strobe, driven off the falling edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_wdata = ~d; // stale data must not be stored
  endtask : wr

  // read answer stands one cycle after the strobe edge
  task automatic rdr(input logic [7:0] a, output logic [15:0] d);
    @(negedge clock);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 1'b0;
    check({15'h0, reg_rvalid}, 16'h0001);
    d = reg_rdata;
  endtask : rdr

  // pulse under test: 0 timeout clock, 1 class d, 2 servo, 3 sequencer tick
  function automatic logic pick(input int sel);
    case (sel)
      0: return timeout_clock;
      1: return classd_clk_tick;
      2: return servo_clk_tick;
      default: return sequencer_clk_tick;
    endcase
  endfunction : pick

  // cycles between two pulses of the selected kind
  task automatic period(input int sel, input logic [15:0] exp);
    int n;
    n = 0;
    while (pick(sel) !== 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (pick(sel) !== 1'b1 && n < 2000);
    check(16'(n), exp);
  endtask : period

  // quiet span: the chosen pulse must never appear
  task automatic quiet(input int sel);
    int hits;
    hits = 0;
    repeat (600) begin
      @(negedge clock);
      if (pick(sel) !== 1'b0) hits++;
    end
    check(16'(hits), 16'h0000);
  endtask : quiet

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------------------
  // watchdog: tests need well under 20000 cycles
  // ---------------------------------------------------------------------------
  initial begin
    #400000;
    fail_count++;
    complete_run();
  end

  // ---------------------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    // reset values of every register and the derived outputs
    foreach (ATK_T[i]) begin
      rdr((i < 5) ? 8'(i == 0 ? 1 : i == 1 ? 6 : i == 2 ? 8'h22 : i == 3 ? 8'h25 : 8'h42)
          : 8'h63, rd);
      check(rd, (i < 5) ? 16'h0000 : 16'h8000);
      if (i == 5) break;
    end
    check({5'h0, power_limit_threshold_mw}, 16'h012C);
    check({11'h0, speaker_boost_half_db}, 16'h0000);
    check({3'h0, gain_recover_rate_ms}, 16'h0438);
    check(gain_reduce_rate_tenth_ms, 16'h04B0);
    check({15'h0, power_limit_enable}, 16'h0001);
    check({15'h0, oscillator_enable}, 16'h0000);
    $display("test reset done");
    // power limit fields: threshold, attack and decay tables, measure mode
    for (int i = 0; i < 16; i++) begin
      wr(8'h63, 16'(i << 8));
      check({5'h0, power_limit_threshold_mw}, 16'(300 + 50 * i));
    end
    for (int i = 0; i < 8; i++) begin
      wr(8'h63, 16'h9000 | 16'(i << 4) | 16'(7 - i));
      check(gain_reduce_rate_tenth_ms, ATK_T[i]);
      check({3'h0, gain_recover_rate_ms}, DCY_T[7 - i]);
      check({15'h0, power_measure_rms_sel}, 16'h0001);
    end
    rdr(8'h63, rd);
    check(rd, 16'h9070);
    wr(8'h63, 16'h0000);
    check({15'h0, power_measure_rms_sel}, 16'h0000);
    check({15'h0, power_limit_enable}, 16'h0000);
    $display("test power limit done");
    // driver mode, attenuation only in class ab, reference, boost in both modes
    wr(8'h25, 16'h00C0);
    check(16'(speaker_drive_mode), 16'(SACC_CLASS_D));
    check({15'h0, speaker_feedback_attenuate}, 16'h0000);
    check({12'h0, speaker_attenuation_db}, 16'h0000);
    check({15'h0, speaker_linear_reference_sel}, 16'h0001);
    wr(8'h22, 16'h1000);
    check(16'(speaker_drive_mode), 16'(SACC_CLASS_AB));
    check({15'h0, speaker_feedback_attenuate}, 16'h0001);
    check({12'h0, speaker_attenuation_db}, 16'h000C);
    for (int m = 0; m < 2; m++) begin
      wr(8'h22, m ? 16'h1000 : 16'h0000);
      for (int i = 0; i < 8; i++) begin
        wr(8'h25, 16'(i << 3));
        check({11'h0, speaker_boost_half_db}, (i == 7) ? 16'h0018 : 16'(3 * i));
      end
    end
    check({15'h0, speaker_linear_reference_sel}, 16'h0000);
    rdr(8'h25, rd);
    check(rd, 16'h0038);
    // unmapped index: write dropped, read gives zero
    wr(8'h10, 16'hFFFF);
    rdr(8'h10, rd);
    check(rd, 16'h0000);
    $display("test speaker done");
    // clocks: nothing while the oscillator is off, then divided pulses
    wr(8'h06, 16'hC000);
    wr(8'h42, 16'h0080);
    quiet(1);
    quiet(0);
    wr(8'h01, 16'h0008);
    check({15'h0, oscillator_enable}, 16'h0001);
    period(1, 16'h0008);
    period(2, 16'h0040);
    period(3, 16'h0100);
    period(0, 16'(BASE));
    wr(8'h06, 16'h4000);
    period(0, 16'(BASE * 2));
    wr(8'h42, 16'h0000);
    period(0, 16'(BASE * 8));
    wr(8'h06, 16'hC000);
    period(0, 16'(BASE * 4));
    wr(8'h42, 16'h0180);
    period(0, 16'(BASE * 16));
    wr(8'h42, 16'h0100);
    wr(8'h06, 16'h4000);
    period(0, 16'(BASE * 128));
    wr(8'h06, 16'h8000);
    quiet(0);
    wr(8'h01, 16'h0000);
    quiet(1);
    $display("test clocks done");
    // joint triggers: clip attack for reduction, power decay for recovery
    wr(8'h63, 16'h8050);
    anticlip_trigger = 1'b1;
    power_trigger = 1'b1;
    repeat (4) @(negedge clock);
    check(gain_reduce_rate_tenth_ms, 16'h0096);
    check({15'h0, gain_recover_power_sel}, 16'h0001);
    anticlip_attack_rate = 3'h7;
    @(negedge clock);
    check(gain_reduce_rate_tenth_ms, 16'h0155);
    wr(8'h63, 16'h0050);
    check({15'h0, gain_recover_power_sel}, 16'h0000);
    anticlip_trigger = 1'b0;
    repeat (4) @(negedge clock);
    check(gain_reduce_rate_tenth_ms, ATK_T[5]);
    $display("test triggers done");
    complete_run();
  end
endmodule : sacc_ctrl_regs_tb
